//--- hw/umf_defines.svh
// Constants for the modem status and flow control block
`ifndef UMF_DEFINES_SVH
`define UMF_DEFINES_SVH

// ==========================================================================
// Register byte offsets
`define UMF_OFS_HLS 8'h00
`define UMF_OFS_SCR 8'h04
`define UMF_OFS_EFC 8'h08
`define UMF_OFS_MCO 8'h0C
`define UMF_OFS_CHR 8'h10
`define UMF_OFS_TRG 8'h14
`define UMF_OFS_IST 8'h18
`define UMF_OFS_IMK 8'h1C

// ==========================================================================
// Reset values
`define UMF_RST_SCR 8'hFF
`define UMF_RST_BYTE 8'h00
`define UMF_RST_WORD 32'h0000_0000
`define UMF_RST_LINES 4'hF

// ==========================================================================
// Field positions
`define UMF_EFC_ACTS 7
`define UMF_EFC_ARTS 6
`define UMF_EFC_TXF 3:2
`define UMF_EFC_RXF 1:0
`define UMF_MCO_DTR 0
`define UMF_MCO_RTS 1
`define UMF_MCO_OP1 2
`define UMF_MCO_OP2 3
`define UMF_MCO_LOOP 4
`define UMF_LN_CTS 0
`define UMF_LN_DSR 1
`define UMF_LN_RI 2
`define UMF_LN_CD 3
`define UMF_IST_MODEM 0
`define UMF_IST_RXTRIG 1
`define UMF_IST_PAUSED 2
`define UMF_CHR_RES1 7:0
`define UMF_CHR_RES2 15:8
`define UMF_CHR_PAU1 23:16
`define UMF_CHR_PAU2 31:24

// ==========================================================================
// Flow character modes, receive FIFO levels and change detection warm-up count
`define UMF_FLOW_OFF 2'h0
`define UMF_FLOW_SECOND 2'h1
`define UMF_FLOW_FIRST 2'h2
`define UMF_FLOW_BOTH 2'h3
`define UMF_LVL_0 6'h01
`define UMF_LVL_1 6'h08
`define UMF_LVL_2 6'h10
`define UMF_LVL_3 6'h18
`define UMF_LVL_4 6'h1C
`define UMF_LVL_5 6'h20
`define UMF_WARM 2'h2

`endif

//--- hw/umf_pkg.sv
// Types for the modem status and flow control block
package umf_pkg;

  typedef enum logic [1:0] {
    SEQ_IDLE,
    SEQ_ONE,
    SEQ_TWO
  } umf_seq_t;

  typedef struct packed {
    logic [3:0] s1;
    logic [3:0] s2;
  } umf_sync_st_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [7:0] scratch;
    logic [7:0] efc;
    logic [7:0] mco;
    logic [31:0] chars;
    logic [1:0] trig_sel;
    logic [3:0] chg;
    logic [3:0] prev;
    logic [1:0] warm;
    logic [2:0] ist;
    logic [2:0] imk;
    logic irq;
    logic msi;
    logic above;
    logic rts_hold;
    logic tx_en;
    logic rem_paused;
    logic half_pause;
    logic half_resume;
    umf_seq_t seq;
    logic seq_pause;
    logic pause_sent;
    logic fc_valid;
    logic [7:0] fc;
    logic rts_n;
    logic dtr_n;
    logic op1_n;
    logic op2_n;
  } umf_state_t;

endpackage : umf_pkg

//--- hw/umf_sync.sv
// Two-stage synchroniser for the four handshake input pins
`timescale 1ns/1ns
`default_nettype none
`include "umf_defines.svh"

module umf_sync (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Pins in, synchronised out
  input wire logic [3:0] din,
  output logic [3:0] dout
);

  umf_pkg::umf_sync_st_t st_r;
  umf_pkg::umf_sync_st_t st_nxt;

  always_comb begin
    st_nxt.s1 = din;
    st_nxt.s2 = st_r.s1;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r.s1 <= `UMF_RST_LINES;
      st_r.s2 <= `UMF_RST_LINES;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign dout = st_r.s2;

endmodule : umf_sync

`default_nettype wire

//--- hw/umf_flow.sv
// Modem status change detection, hardware and software flow control, APB registers
//
// Chosen here: the APB register port and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
`include "umf_defines.svh"

module umf_flow (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Handshake pins
  input wire logic cts_n,
  input wire logic dsr_n,
  input wire logic ri_n,
  input wire logic cd_n,
  output logic rts_n,
  output logic dtr_n,
  output logic op1_n,
  output logic op2_n,
  // Transmitter side
  input wire logic tx_idle,
  output logic tx_enable,
  output logic flow_char_valid,
  output logic [7:0] flow_char,
  input wire logic flow_char_ready,
  // Receiver side
  input wire logic [5:0] rx_level,
  input wire logic rx_char_valid,
  input wire logic [7:0] rx_char,
  input wire logic hw_flow_en,
  // Interrupts
  output logic irq,
  output logic modem_irq
);

  umf_pkg::umf_state_t st_r;
  umf_pkg::umf_state_t st_nxt;
  logic [3:0] pins_sync;

  // ==========================================================================
  // Pin synchroniser
  umf_sync u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .din({cd_n, ri_n, dsr_n, cts_n}),
    .dout(pins_sync)
  );

  // Receive FIFO level ladder, index 0 is the floor below the lowest trigger
  function automatic logic [5:0] lvl(input logic [2:0] idx);
    case (idx)
      3'h0: lvl = `UMF_LVL_0;
      3'h1: lvl = `UMF_LVL_1;
      3'h2: lvl = `UMF_LVL_2;
      3'h3: lvl = `UMF_LVL_3;
      3'h4: lvl = `UMF_LVL_4;
      default: lvl = `UMF_LVL_5;
    endcase
  endfunction : lvl

  // ==========================================================================
  // Next-state logic
  always_comb begin
    logic setup;
    logic access;
    logic wr;
    logic rd_hls;
    logic loop;
    logic [3:0] cur;
    logic [3:0] chg_set;
    logic [2:0] ev;
    logic [2:0] w1c;
    logic [5:0] lvl_low;
    logic [5:0] lvl_trig;
    logic [5:0] lvl_next;
    logic [1:0] txm;
    logic [1:0] rxm;
    logic cts_stop;
    logic hit_p1;
    logic hit_p2;
    logic hit_r1;
    logic hit_r2;
    logic [31:0] rdata;
    logic mapped;
    setup = psel & ~penable;
    access = psel & penable & st_r.pready;
    wr = access & pwrite;
    rd_hls = access & ~pwrite & (paddr == `UMF_OFS_HLS);
    loop = st_r.mco[`UMF_MCO_LOOP];
    chg_set = 4'h0;
    ev = 3'h0;
    w1c = 3'h0;
    cur = 4'h0;
    mapped = 1'b1;
    rdata = `UMF_RST_WORD;
    lvl_low = 6'h00;
    lvl_trig = 6'h00;
    lvl_next = 6'h00;
    txm = 2'h0;
    rxm = 2'h0;
    cts_stop = 1'b0;
    hit_p1 = 1'b0;
    hit_p2 = 1'b0;
    hit_r1 = 1'b0;
    hit_r2 = 1'b0;
    st_nxt = st_r;

    // Line levels in asserted sense; loop-back takes the control outputs
    if (loop) begin
      cur[`UMF_LN_CTS] = st_r.mco[`UMF_MCO_RTS];
      cur[`UMF_LN_DSR] = st_r.mco[`UMF_MCO_DTR];
      cur[`UMF_LN_RI] = st_r.mco[`UMF_MCO_OP1];
      cur[`UMF_LN_CD] = st_r.mco[`UMF_MCO_OP2];
    end else begin
      cur = ~pins_sync;
    end

    // ========================================================================
    // APB read mux, sampled in the setup cycle
    case (paddr)
      `UMF_OFS_HLS: rdata[7:0] = {cur, st_r.chg};
      `UMF_OFS_SCR: rdata[7:0] = st_r.scratch;
      `UMF_OFS_EFC: rdata[7:0] = st_r.efc;
      `UMF_OFS_MCO: rdata[7:0] = st_r.mco;
      `UMF_OFS_CHR: rdata = st_r.chars;
      `UMF_OFS_TRG: rdata[1:0] = st_r.trig_sel;
      `UMF_OFS_IST: rdata[2:0] = st_r.ist;
      `UMF_OFS_IMK: rdata[2:0] = st_r.imk;
      default: mapped = 1'b0;
    endcase
    st_nxt.pready = setup;
    if (setup) begin
      st_nxt.prdata = pwrite ? `UMF_RST_WORD : rdata;
      st_nxt.pslverr = ~mapped;
    end

    // ========================================================================
    // Register writes
    if (wr) begin
      case (paddr)
        `UMF_OFS_SCR: st_nxt.scratch = pwdata[7:0];
        `UMF_OFS_EFC: st_nxt.efc = pwdata[7:0];
        `UMF_OFS_MCO: st_nxt.mco = pwdata[7:0];
        `UMF_OFS_CHR: st_nxt.chars = pwdata;
        `UMF_OFS_TRG: st_nxt.trig_sel = pwdata[1:0];
        `UMF_OFS_IST: w1c = pwdata[2:0];
        `UMF_OFS_IMK: st_nxt.imk = pwdata[2:0];
        default: st_nxt.scratch = st_r.scratch;
      endcase
    end
    if (!hw_flow_en) begin
      st_nxt.efc[`UMF_EFC_ARTS] = 1'b0;
    end

    // ========================================================================
    // Change detection; flags set in the read's own cycle survive the clear
    if (st_r.warm != `UMF_WARM) begin
      st_nxt.warm = st_r.warm + 2'h1;
    end else begin
      chg_set[`UMF_LN_CTS] = cur[`UMF_LN_CTS] ^ st_r.prev[`UMF_LN_CTS];
      chg_set[`UMF_LN_DSR] = cur[`UMF_LN_DSR] ^ st_r.prev[`UMF_LN_DSR];
      chg_set[`UMF_LN_RI] = st_r.prev[`UMF_LN_RI] & ~cur[`UMF_LN_RI];
      chg_set[`UMF_LN_CD] = cur[`UMF_LN_CD] ^ st_r.prev[`UMF_LN_CD];
    end
    st_nxt.prev = cur;
    if (rd_hls) begin
      st_nxt.chg = st_r.chg & ~st_r.prdata[3:0];
    end
    st_nxt.chg = st_nxt.chg | chg_set;
    ev[`UMF_IST_MODEM] = |(chg_set & ~st_r.chg);

    // ========================================================================
    // Automatic RTS against receive FIFO trigger levels
    lvl_low = lvl({1'b0, st_r.trig_sel});
    lvl_trig = lvl({1'b0, st_r.trig_sel} + 3'h1);
    lvl_next = lvl({1'b0, st_r.trig_sel} + 3'h2);
    st_nxt.above = rx_level >= lvl_trig;
    ev[`UMF_IST_RXTRIG] = st_r.efc[`UMF_EFC_ARTS] & st_nxt.above & ~st_r.above;
    if (rx_level >= lvl_next) begin
      st_nxt.rts_hold = 1'b1;
    end else if (rx_level < lvl_low) begin
      st_nxt.rts_hold = 1'b0;
    end

    // ========================================================================
    // Outgoing pause and resume character sequences
    txm = st_r.efc[`UMF_EFC_TXF];
    case (st_r.seq)
      umf_pkg::SEQ_IDLE: begin
        if (txm != `UMF_FLOW_OFF) begin
          if (!st_r.pause_sent && rx_level >= lvl_next) begin
            st_nxt.seq = umf_pkg::SEQ_ONE;
            st_nxt.seq_pause = 1'b1;
            st_nxt.fc_valid = 1'b1;
            st_nxt.fc = (txm == `UMF_FLOW_SECOND) ? st_r.chars[`UMF_CHR_PAU2] : st_r.chars[`UMF_CHR_PAU1];
          end else if (st_r.pause_sent && rx_level < lvl_low) begin
            st_nxt.seq = umf_pkg::SEQ_ONE;
            st_nxt.seq_pause = 1'b0;
            st_nxt.fc_valid = 1'b1;
            st_nxt.fc = (txm == `UMF_FLOW_SECOND) ? st_r.chars[`UMF_CHR_RES2] : st_r.chars[`UMF_CHR_RES1];
          end
        end else begin
          st_nxt.pause_sent = 1'b0;
        end
      end
      umf_pkg::SEQ_ONE: begin
        if (flow_char_ready) begin
          if (txm == `UMF_FLOW_BOTH) begin
            st_nxt.seq = umf_pkg::SEQ_TWO;
            st_nxt.fc = st_r.seq_pause ? st_r.chars[`UMF_CHR_PAU2] : st_r.chars[`UMF_CHR_RES2];
          end else begin
            st_nxt.seq = umf_pkg::SEQ_IDLE;
            st_nxt.fc_valid = 1'b0;
            st_nxt.pause_sent = st_r.seq_pause;
          end
        end
      end
      umf_pkg::SEQ_TWO: begin
        if (flow_char_ready) begin
          st_nxt.seq = umf_pkg::SEQ_IDLE;
          st_nxt.fc_valid = 1'b0;
          st_nxt.pause_sent = st_r.seq_pause;
        end
      end
      default: begin
        st_nxt.seq = umf_pkg::SEQ_IDLE;
        st_nxt.fc_valid = 1'b0;
      end
    endcase

    // ========================================================================
    // Incoming pause and resume character matching
    rxm = st_r.efc[`UMF_EFC_RXF];
    hit_p1 = rx_char == st_r.chars[`UMF_CHR_PAU1];
    hit_p2 = rx_char == st_r.chars[`UMF_CHR_PAU2];
    hit_r1 = rx_char == st_r.chars[`UMF_CHR_RES1];
    hit_r2 = rx_char == st_r.chars[`UMF_CHR_RES2];
    if (rxm == `UMF_FLOW_OFF) begin
      st_nxt.rem_paused = 1'b0;
      st_nxt.half_pause = 1'b0;
      st_nxt.half_resume = 1'b0;
    end else if (rx_char_valid) begin
      if (rxm == `UMF_FLOW_BOTH) begin
        st_nxt.half_pause = hit_p1;
        st_nxt.half_resume = hit_r1;
        if (st_r.half_pause && hit_p2) begin
          st_nxt.rem_paused = 1'b1;
        end else if (st_r.half_resume && hit_r2) begin
          st_nxt.rem_paused = 1'b0;
        end
      end else if (rxm == `UMF_FLOW_FIRST) begin
        if (hit_p1) begin
          st_nxt.rem_paused = 1'b1;
        end else if (hit_r1) begin
          st_nxt.rem_paused = 1'b0;
        end
      end else begin
        if (hit_p2) begin
          st_nxt.rem_paused = 1'b1;
        end else if (hit_r2) begin
          st_nxt.rem_paused = 1'b0;
        end
      end
    end
    ev[`UMF_IST_PAUSED] = st_nxt.rem_paused & ~st_r.rem_paused;

    // ========================================================================
    // Transmit gate, only re-evaluated between characters
    cts_stop = st_r.efc[`UMF_EFC_ACTS] & ~cur[`UMF_LN_CTS];
    if (tx_idle) begin
      st_nxt.tx_en = ~cts_stop & ~st_r.rem_paused;
    end

    // ========================================================================
    // Handshake outputs, held inactive in loop-back
    if (loop) begin
      st_nxt.rts_n = 1'b1;
      st_nxt.dtr_n = 1'b1;
      st_nxt.op1_n = 1'b1;
      st_nxt.op2_n = 1'b1;
    end else begin
      if (st_nxt.efc[`UMF_EFC_ARTS]) begin
        st_nxt.rts_n = ~st_nxt.mco[`UMF_MCO_RTS] | st_nxt.rts_hold;
      end else begin
        st_nxt.rts_n = ~st_nxt.mco[`UMF_MCO_RTS];
      end
      st_nxt.dtr_n = ~st_nxt.mco[`UMF_MCO_DTR];
      st_nxt.op1_n = ~st_nxt.mco[`UMF_MCO_OP1];
      st_nxt.op2_n = ~st_nxt.mco[`UMF_MCO_OP2];
    end

    // ========================================================================
    // Interrupts: sticky status, write one to clear, set wins
    st_nxt.ist = (st_r.ist & ~w1c) | ev;
    st_nxt.irq = |(st_nxt.ist & st_nxt.imk);
    st_nxt.msi = |st_nxt.chg;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= '0;
      st_r.scratch <= `UMF_RST_SCR;
      st_r.efc <= `UMF_RST_BYTE;
      st_r.tx_en <= 1'b1;
      st_r.seq <= umf_pkg::SEQ_IDLE;
      st_r.rts_n <= 1'b1;
      st_r.dtr_n <= 1'b1;
      st_r.op1_n <= 1'b1;
      st_r.op2_n <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ==========================================================================
  // Outputs
  assign prdata = st_r.prdata;
  assign pready = st_r.pready;
  assign pslverr = st_r.pslverr;
  assign rts_n = st_r.rts_n;
  assign dtr_n = st_r.dtr_n;
  assign op1_n = st_r.op1_n;
  assign op2_n = st_r.op2_n;
  assign tx_enable = st_r.tx_en;
  assign flow_char_valid = st_r.fc_valid;
  assign flow_char = st_r.fc;
  assign irq = st_r.irq;
  assign modem_irq = st_r.msi;

endmodule : umf_flow

`default_nettype wire

//--- sim/umf_flow_asserts.sv
// Checker for the modem status and flow control block
`timescale 1ns/1ns
`default_nettype none
`include "umf_defines.svh"

module umf_flow_asserts (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Pins and side ports
  input wire logic cts_n,
  input wire logic rts_n,
  input wire logic tx_idle,
  input wire logic tx_enable,
  input wire logic flow_char_valid,
  input wire logic [7:0] flow_char,
  input wire logic flow_char_ready,
  input wire logic [5:0] rx_level,
  input wire logic hw_flow_en,
  input wire logic modem_irq
);
  // ==========================================================================
  // Shadow of the feature and control registers
  logic [7:0] efc_r;
  logic [7:0] mco_r;
  logic [1:0] trg_r;
  logic wr;
  assign wr = psel && penable && pready && pwrite;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      efc_r <= 8'h00;
      mco_r <= 8'h00;
      trg_r <= 2'h0;
    end else begin
      if (wr && paddr == `UMF_OFS_EFC) efc_r <= pwdata[7:0];
      if (!hw_flow_en) efc_r[6] <= 1'b0;
      if (wr && paddr == `UMF_OFS_MCO) mco_r <= pwdata[7:0];
      if (wr && paddr == `UMF_OFS_TRG) trg_r <= pwdata[1:0];
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // ==========================================================================
  // Assertions
  a_pready_once: assert property (psel && !penable |=> pready ##1 !pready)
    else $error("pready not a single access cycle");
  a_unmapped_err: assert property (psel && !penable && paddr > `UMF_OFS_IMK |=> pslverr)
    else $error("no slave error on unmapped address");
  a_msi_follow: assert property (pready && !pwrite && paddr == `UMF_OFS_HLS |-> modem_irq == |prdata[3:0])
    else $error("modem interrupt disagrees with change flags");
  a_rts_manual: assert property ($past(presetn) && !efc_r[6] && !$past(efc_r[6]) && !mco_r[4]
      && $past(mco_r[4:1]) == mco_r[4:1] |-> rts_n == !mco_r[1])
    else $error("rts pin not following control bit");
  a_rts_raise: assert property ((efc_r[6] && mco_r[1] && !mco_r[4]
      && rx_level >= (trg_r == 2'h0 ? 6'h10 : 6'h20))[*4] |-> rts_n)
    else $error("rts pin not raised at next level");
  a_rts_drop: assert property ((efc_r[6] && mco_r[1] && !mco_r[4] && rx_level == 6'h00)[*4] |-> !rts_n)
    else $error("rts pin not released below lower level");
  a_cts_halt: assert property ((efc_r[7] && !mco_r[4] && tx_idle && cts_n)[*5] |=> !tx_enable)
    else $error("transmit not halted by cts");
  a_cts_resume: assert property ((efc_r[7] && efc_r[1:0] == 2'h0 && !mco_r[4] && tx_idle && !cts_n)[*5]
      |=> tx_enable)
    else $error("transmit not resumed by cts");
  a_char_whole: assert property (!tx_idle |=> $stable(tx_enable))
    else $error("transmit enable changed inside a character");
  a_flow_hold: assert property (flow_char_valid && !flow_char_ready |=> flow_char_valid && $stable(flow_char))
    else $error("flow character dropped before taken");

  c_rts_high: cover property (efc_r[6] && rts_n);
  c_flow_take: cover property (flow_char_valid && flow_char_ready);
  c_modem_irq: cover property (modem_irq);
  c_tx_halt: cover property (efc_r[7] && !tx_enable);
endmodule : umf_flow_asserts

bind umf_flow umf_flow_asserts i_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
  .pready, .pslverr, .cts_n, .rts_n, .tx_idle, .tx_enable, .flow_char_valid, .flow_char, .flow_char_ready,
  .rx_level, .hw_flow_en, .modem_irq);
`default_nettype wire

//--- sim/umf_peer.sv
// Modem side model: handshake pins and flow character sink
`timescale 1ns/1ns
`default_nettype none

module umf_peer (
  // Clock
  input wire logic pclk,
  // Pin levels asked for and stall request
  input wire logic [3:0] want,
  input wire logic stall,
  // Handshake pins
  output logic [3:0] pins,
  // Flow character sink
  input wire logic flow_char_valid,
  input wire logic [7:0] flow_char,
  output logic flow_char_ready
);
  logic [7:0] prev = 8'h00;
  logic [7:0] last = 8'h00;
  int n = 0;
  initial begin
    pins = 4'hF;
    flow_char_ready = 1'b0;
  end
  // Stalling sink alternates ready so held characters are exercised
  always @(posedge pclk) begin
    pins <= want;
    flow_char_ready <= stall ? !flow_char_ready : 1'b1;
    if (flow_char_valid && flow_char_ready) begin
      prev <= last;
      last <= flow_char;
      n <= n + 1;
    end
  end
endmodule : umf_peer
`default_nettype wire

//--- sim/umf_flow_test.sv
// Self-checking testbench for the modem status and flow control block
`timescale 1ns/1ns
`default_nettype none
`include "umf_defines.svh"

module umf_flow_test;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, tx_idle = 1;
  logic rx_char_valid = 0, hw_flow_en = 1, stall = 0, inj = 0, quiet = 0, pready, pslverr, er;
  logic rts_n, dtr_n, op1_n, op2_n, tx_enable, fcv, fcr, irq, modem_irq;
  logic [7:0] paddr = 8'h00, rx_char = 8'h00, ichr = 8'h00, fc;
  logic [31:0] pwdata = 32'h0, prdata, rd, d;
  logic [5:0] rx_level = 6'h00;
  logic [5:0] lv [4] = '{6'h08, 6'h10, 6'h08, 6'h00};
  logic [3:0] want = 4'hF, pins, ex = 4'b0110;
  integer seed = 32'hD6D95E54;
  int err_count = 0, compares = 0, base;

  umf_flow i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .cts_n(pins[0]),
    .dsr_n(pins[1]), .ri_n(pins[2]), .cd_n(pins[3]), .rts_n(rts_n), .dtr_n(dtr_n), .op1_n(op1_n),
    .op2_n(op2_n), .tx_idle(tx_idle), .tx_enable(tx_enable), .flow_char_valid(fcv), .flow_char(fc),
    .flow_char_ready(fcr), .rx_level(rx_level), .rx_char_valid(rx_char_valid), .rx_char(rx_char),
    .hw_flow_en(hw_flow_en), .irq(irq), .modem_irq(modem_irq));
  umf_peer i_peer (.pclk(pclk), .want(want), .stall(stall), .pins(pins), .flow_char_valid(fcv),
    .flow_char(fc), .flow_char_ready(fcr));

  always #50 pclk = ~pclk;
  // Random receive traffic, silenced while chosen characters are injected
  always @(posedge pclk) begin
    rx_char_valid <= inj || (!quiet && ($random(seed) & 3) == 0);
    rx_char <= inj ? ichr : 8'($random(seed));
  end

  // ==========================================================================
  // Tasks
  task automatic tick(input int k);
    repeat (k) @(posedge pclk);
  endtask : tick
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] v);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= v;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rxc(input logic [7:0] c);
    @(posedge pclk);
    inj <= 1'b1;
    ichr <= c;
    @(posedge pclk);
    inj <= 1'b0;
  endtask : rxc
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      err_count++;
      $display("FAIL %0t word %h expected %h", $time, g, e);
    end
  endtask : chk
  task automatic chk1(input logic g, input logic e);
    compares++;
    if (g !== e) begin
      err_count++;
      $display("FAIL %0t bit %b expected %b", $time, g, e);
    end
  endtask : chk1
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd, e);
  endtask : rdc
  task automatic print_verdict;
    $display("compares %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : print_verdict
  // Last character expected of a mode: first character alone only in mode 2
  function automatic logic [7:0] exp_last(input int m, input logic [15:0] pr);
    return (m == 2) ? pr[7:0] : pr[15:8];
  endfunction : exp_last

  initial begin
    #(4000 * 100);
    err_count++;
    print_verdict();
  end

  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 8; i++) rdc(8'(i * 4), i == 1 ? 32'hFF : 32'h0);
    apb(1'b0, 8'h20, 32'h0);
    chk({er, rd[30:0]}, 32'h8000_0000);
    $display("test reset done");
    repeat (4) begin
      d = $random(seed);
      apb(1'b1, `UMF_OFS_SCR, d);
      rdc(`UMF_OFS_SCR, d & 32'hFF);
    end
    rdc(`UMF_OFS_EFC, 32'h0);
    $display("test scratch done");
    want <= 4'hC;
    tick(8);
    chk1(irq, 1'b0);
    chk1(modem_irq, 1'b1);
    rdc(`UMF_OFS_HLS, 32'h33);
    rdc(`UMF_OFS_HLS, 32'h30);
    tick(2);
    chk1(modem_irq, 1'b0);
    apb(1'b1, `UMF_OFS_IMK, 32'h1);
    tick(2);
    chk1(irq, 1'b1);
    apb(1'b1, `UMF_OFS_IST, 32'h1);
    tick(2);
    chk1(irq, 1'b0);
    $display("test modem change done");
    apb(1'b1, `UMF_OFS_MCO, 32'h13);
    tick(3);
    chk({rts_n, dtr_n, op1_n, op2_n}, 4'hF);
    apb(1'b0, `UMF_OFS_HLS, 32'h0);
    chk(rd & 32'hF0, 32'h30);
    apb(1'b1, `UMF_OFS_MCO, 32'h1C);
    tick(3);
    apb(1'b0, `UMF_OFS_HLS, 32'h0);
    chk(rd & 32'hF0, 32'hC0);
    apb(1'b1, `UMF_OFS_MCO, 32'h0);
    tick(4);
    apb(1'b0, `UMF_OFS_HLS, 32'h0);
    apb(1'b1, `UMF_OFS_IST, 32'h7);
    $display("test loop-back done");
    apb(1'b1, `UMF_OFS_MCO, 32'hB);
    tick(2);
    chk({rts_n, dtr_n, op1_n, op2_n}, 4'h2);
    apb(1'b1, `UMF_OFS_IMK, 32'h2);
    apb(1'b1, `UMF_OFS_EFC, 32'h40);
    for (int i = 0; i < 4; i++) begin
      rx_level <= lv[i];
      tick(6);
      chk1(rts_n, ex[i]);
      if (i == 0) chk1(irq, 1'b1);
    end
    apb(1'b1, `UMF_OFS_TRG, 32'h1);
    rx_level <= 6'h10;
    tick(6);
    chk1(rts_n, 1'b0);
    rx_level <= 6'h18;
    tick(6);
    chk1(rts_n, 1'b1);
    rx_level <= 6'h07;
    tick(6);
    chk1(rts_n, 1'b0);
    apb(1'b1, `UMF_OFS_TRG, 32'h0);
    hw_flow_en <= 1'b0;
    tick(2);
    rdc(`UMF_OFS_EFC, 32'h0);
    hw_flow_en <= 1'b1;
    apb(1'b1, `UMF_OFS_IMK, 32'h0);
    $display("test auto rts done");
    apb(1'b1, `UMF_OFS_EFC, 32'h80);
    want <= 4'hD;
    tick(6);
    chk1(tx_enable, 1'b0);
    tx_idle <= 1'b0;
    want <= 4'hC;
    tick(6);
    chk1(tx_enable, 1'b0);
    tx_idle <= 1'b1;
    tick(2);
    chk1(tx_enable, 1'b1);
    repeat (40) begin
      @(posedge pclk);
      tx_idle <= 1'($random(seed));
      want[0] <= ($random(seed) & 7) == 0;
    end
    @(posedge pclk);
    want <= 4'hC;
    tx_idle <= 1'b1;
    $display("test auto cts done");
    d = $random(seed);
    apb(1'b1, `UMF_OFS_CHR, d);
    stall <= 1'b1;
    for (int m = 3; m > 0; m--) begin
      apb(1'b1, `UMF_OFS_EFC, m << 2);
      for (int p = 0; p < 2; p++) begin
        base = i_peer.n;
        rx_level <= p ? 6'h00 : 6'h10;
        for (int k = 0; k < 60 && i_peer.n < base + (m == 3 ? 2 : 1); k++) tick(1);
        tick(8);
        chk(i_peer.n - base, m == 3 ? 2 : 1);
        chk(i_peer.last, exp_last(m, p ? d[15:0] : d[31:16]));
        if (m == 3) chk(i_peer.prev, p ? d[7:0] : d[23:16]);
      end
      apb(1'b1, `UMF_OFS_EFC, 32'h0);
    end
    $display("test flow characters done");
    apb(1'b1, `UMF_OFS_CHR, 32'h5A3C_A5C3);
    apb(1'b1, `UMF_OFS_IMK, 32'h4);
    quiet <= 1'b1;
    for (int m = 3; m > 0; m -= 2) begin
      apb(1'b1, `UMF_OFS_EFC, m);
      if (m == 3) rxc(8'h3C);
      rxc(8'h5A);
      tick(4);
      chk1(tx_enable, 1'b0);
      chk1(irq, 1'b1);
      apb(1'b1, `UMF_OFS_IST, 32'h4);
      if (m == 3) rxc(8'hC3);
      rxc(8'hA5);
      tick(4);
      chk1(tx_enable, 1'b1);
    end
    $display("test receive flow done");
    print_verdict();
  end
endmodule : umf_flow_test
`default_nettype wire
